// >>> pkg/spb_regs.vh
// Register map, field positions and constants of the serial port block
`ifndef SPB_REGS_VH
`define SPB_REGS_VH
`define SPB_OFF_TXSC    8'h00
`define SPB_OFF_RXSC    8'h04
`define SPB_OFF_BAUDC   8'h08
`define SPB_OFF_DIVL    8'h0c
`define SPB_OFF_DIVH    8'h10
`define SPB_OFF_RXDATA  8'h14
`define SPB_TX_CMS      7
`define SPB_TX_NINE     6
`define SPB_TX_EN       5
`define SPB_TX_SYNC     4
`define SPB_TX_BRK      3
`define SPB_TX_HRS      2
`define SPB_TX_EMPTY    1
`define SPB_TX_D9       0
`define SPB_RX_PEN      7
`define SPB_RX_NINE     6
`define SPB_RX_SGL      5
`define SPB_RX_CONT     4
`define SPB_RX_ADET     3
`define SPB_RX_FRM      2
`define SPB_RX_OVR      1
`define SPB_RX_D9       0
`define SPB_BD_ABOVF    7
`define SPB_BD_IDLE     6
`define SPB_BD_POL      4
`define SPB_BD_WIDE     3
`define SPB_BD_WAKE     1
`define SPB_BD_ABEN     0
`define SPB_RST_TXSC    8'h02
`define SPB_RST_RXSC    8'h00
`define SPB_RST_BAUDC   8'h40
`define SPB_RST_DIV     8'h00
`define SPB_PRE_X64     2'h0
`define SPB_PRE_X16     2'h1
`define SPB_PRE_X4      2'h2
`define SPB_LAST_X64    6'h3f
`define SPB_LAST_X16    6'h0f
`define SPB_LAST_X4     6'h03
`endif

// >>> logic/spb_baud_gen.v
// Baud timer with reload, restart and bit-rate prescaler
`timescale 1ns/1ns
`include "spb_regs.vh"
module spb_baud_gen #(
  parameter DIV_W = 16
) (
  input  wire             core_clk,
  input  wire             rst_n,
  input  wire             run,
  input  wire             restart,
  input  wire             wide,
  input  wire [1:0]       pre_sel,
  input  wire [DIV_W-1:0] div_val,
  output reg              timer_tick_r,
  output reg              bit_tick_r
);
  reg  [DIV_W-1:0] cnt_r;
  reg  [5:0]       pre_r;
  reg  [5:0]       pre_last;
  wire [DIV_W-1:0] reload;

  // Eight-bit mode uses only the low divisor byte
  assign reload = wide ? div_val : {{(DIV_W-8){1'b0}}, div_val[7:0]};

  always @* begin
    if (pre_sel == `SPB_PRE_X64) begin
      pre_last = `SPB_LAST_X64;
    end else if (pre_sel == `SPB_PRE_X16) begin
      pre_last = `SPB_LAST_X16;
    end else begin
      pre_last = `SPB_LAST_X4;
    end
  end

  always @(posedge core_clk) begin
    if (!rst_n || !run || restart) begin
      cnt_r        <= reload;
      pre_r        <= 6'h00;
      timer_tick_r <= 1'b0;
      bit_tick_r   <= 1'b0;
    end else if (cnt_r == {DIV_W{1'b0}}) begin
      cnt_r        <= reload;
      timer_tick_r <= 1'b1;
      if (pre_r == pre_last) begin
        pre_r      <= 6'h00;
        bit_tick_r <= 1'b1;
      end else begin
        pre_r      <= pre_r + 6'h01;
        bit_tick_r <= 1'b0;
      end
    end else begin
      cnt_r        <= cnt_r - {{(DIV_W-1){1'b0}}, 1'b1};
      timer_tick_r <= 1'b0;
      bit_tick_r   <= 1'b0;
    end
  end
endmodule // spb_baud_gen

// >>> logic/spb_ctrl.v
// Serial port control/status registers, receive FIFO and baud generator
`timescale 1ns/1ns
`include "spb_regs.vh"
// Contract
// - Clock master only when synchronous and selected
// - Separate nine-bit selects, eight-bit after reset
// - Transmit enable; sync receive overrides transmit
// - Mode bit selects sync, resets async
// - Break request cleared on completion, async only
// - High-rate select used in async only
// - Shift register empty flag, reset one
// - Writable ninth transmit data bit
// - Port enable clear holds port reset
// - Single receive, sync master, self clearing
// - Continuous receive enables, overrides single receive
// - Address detect keeps ninth-bit-set characters only in async nine-bit mode
// - Framing error of top unread character
// - Overrun cleared by clearing continuous receive
// - Received ninth bit shown, no parity check
// - Auto-baud overflow flag in async mode
// - Receiver idle flag, reset one
// - Polarity inverts data or selects edge
// - Eight-bit timer default, sixteen when wide
// - Wake-up waits falling edge, sets flag, clears
// - Auto-baud enable cleared when detection completes
// - Divisor write restarts timer one cycle after the write
// - Baud divisor 64, 16 or 4 times n+1
// - Two-deep FIFO, third character overruns
module spb_ctrl #(
  parameter RX_DEPTH = 2,
  parameter PTR_W    = 1,
  parameter DIV_W    = 16
) (
  input  wire        core_clk,
  input  wire        rst_n,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata_r,
  output reg         pready_r,
  output reg         pslverr_r,
  input  wire        txsh_empty,
  input  wire        rx_busy,
  input  wire        rx_char_done,
  input  wire [7:0]  rx_char_data,
  input  wire        rx_char_ninth,
  input  wire        rx_char_frm,
  input  wire        break_done,
  input  wire        autobaud_done,
  input  wire        autobaud_ovf,
  input  wire        rx_pin,
  output reg         port_enable_r,
  output reg         sync_mode_r,
  output reg         clock_master_r,
  output reg         tx_active_r,
  output reg         rx_active_r,
  output reg         tx_nine_r,
  output reg         rx_nine_r,
  output reg         tx_ninth_r,
  output reg         break_pending_r,
  output reg         polarity_r,
  output reg         wake_armed_r,
  output reg         autobaud_armed_r,
  output reg         receive_interrupt_flag_r,
  output wire        timer_tick_r,
  output wire        bit_tick_r
);
  // Control bits
  reg        clock_master_select_r;
  reg        transmit_nine_bit_select_r;
  reg        transmit_enable_bit_r;
  reg        sync_bit_r;
  reg        break_request_r;
  reg        high_rate_select_r;
  reg        shift_register_empty_r;
  reg        transmit_ninth_data_r;
  reg        port_enable_bit_r;
  reg        receive_nine_bit_select_r;
  reg        single_receive_enable_r;
  reg        continuous_receive_enable_r;
  reg        address_detect_enable_r;
  reg        overrun_error_flag_r;
  reg        autobaud_overflow_flag_r;
  reg        receiver_idle_flag_r;
  reg        polarity_select_r;
  reg        wide_generator_select_r;
  reg        wakeup_enable_r;
  reg        autobaud_enable_r;
  reg        wake_flag_r;
  reg [7:0]  divisor_low_r;
  reg [7:0]  divisor_high_r;
  reg        div_restart_r;
  // Receive pin synchroniser
  reg        rx_meta_r;
  reg        rx_sync_r;
  reg        rx_prev_r;
  // Receive FIFO
  reg [9:0]       fifo_mem_r [0:RX_DEPTH-1];
  reg [PTR_W-1:0] wr_ptr_r;
  reg [PTR_W-1:0] rd_ptr_r;
  reg [PTR_W:0]   fifo_cnt_r;
  // Bus decode
  wire       setup_ph;
  wire       acc_done;
  wire       wr_en;
  wire       rd_en;
  reg        addr_hit;
  reg [7:0]  rd_byte;
  reg [7:0]  tx_rd;
  reg [7:0]  rx_rd;
  reg [7:0]  bd_rd;
  // Receive datapath
  wire       fifo_empty;
  wire       fifo_full;
  wire       single_act;
  wire       rx_on;
  wire       char_ok;
  wire       push;
  wire       pop;
  wire       overrun_set;
  wire       wake_edge;
  wire [9:0] head;
  wire [1:0] pre_sel;
  wire       wr_tx;
  wire       wr_rx;
  wire       wr_bd;
  wire       wr_div;
  wire [PTR_W:0] cnt_nxt;
  wire       wake_nxt;

  assign setup_ph = psel & ~penable;
  assign acc_done = psel & penable & pready_r;
  assign wr_en    = acc_done & pwrite;
  assign rd_en    = acc_done & ~pwrite;
  assign wr_tx    = wr_en & (paddr == `SPB_OFF_TXSC);
  assign wr_rx    = wr_en & (paddr == `SPB_OFF_RXSC);
  assign wr_bd    = wr_en & (paddr == `SPB_OFF_BAUDC);
  assign wr_div   = wr_en & ((paddr == `SPB_OFF_DIVL) |
                             (paddr == `SPB_OFF_DIVH));

  assign fifo_empty = (fifo_cnt_r == {(PTR_W+1){1'b0}});
  assign fifo_full  = (fifo_cnt_r == RX_DEPTH[PTR_W:0]);
  assign head       = fifo_mem_r[rd_ptr_r];
  // Continuous receive wins over single receive
  assign single_act = sync_bit_r & clock_master_select_r &
                      single_receive_enable_r &
                      ~continuous_receive_enable_r;
  assign rx_on      = port_enable_bit_r &
                      (continuous_receive_enable_r | single_act);
  assign char_ok    = sync_bit_r | ~receive_nine_bit_select_r |
                      ~address_detect_enable_r | rx_char_ninth;
  assign push       = rx_char_done & rx_on & char_ok &
                      ~overrun_error_flag_r & ~fifo_full;
  assign overrun_set = rx_char_done & rx_on & char_ok & fifo_full;
  assign pop        = rd_en & (paddr == `SPB_OFF_RXDATA) &
                      ~fifo_empty;
  assign wake_edge  = port_enable_bit_r & ~sync_bit_r & wakeup_enable_r &
                      rx_prev_r & ~rx_sync_r;
  assign cnt_nxt    = fifo_cnt_r + {{PTR_W{1'b0}}, push} -
                      {{PTR_W{1'b0}}, pop};
  assign wake_nxt   = port_enable_bit_r &
                      (wake_edge | (wake_flag_r & ~(rd_en &
                       (paddr == `SPB_OFF_RXDATA))));
  // Multiplier: 64, 16 or 4 depending on mode, width and high rate
  assign pre_sel = sync_bit_r ? `SPB_PRE_X4 :
                   (wide_generator_select_r & high_rate_select_r) ?
                   `SPB_PRE_X4 :
                   (wide_generator_select_r | high_rate_select_r) ?
                   `SPB_PRE_X16 : `SPB_PRE_X64;

  // Register readback
  always @* begin
    tx_rd = 8'h00;
    tx_rd[`SPB_TX_CMS]   = clock_master_select_r;
    tx_rd[`SPB_TX_NINE]  = transmit_nine_bit_select_r;
    tx_rd[`SPB_TX_EN]    = transmit_enable_bit_r;
    tx_rd[`SPB_TX_SYNC]  = sync_bit_r;
    tx_rd[`SPB_TX_BRK]   = break_request_r;
    tx_rd[`SPB_TX_HRS]   = high_rate_select_r;
    tx_rd[`SPB_TX_EMPTY] = shift_register_empty_r;
    tx_rd[`SPB_TX_D9]    = transmit_ninth_data_r;
    rx_rd = 8'h00;
    rx_rd[`SPB_RX_PEN]   = port_enable_bit_r;
    rx_rd[`SPB_RX_NINE]  = receive_nine_bit_select_r;
    rx_rd[`SPB_RX_SGL]   = single_receive_enable_r;
    rx_rd[`SPB_RX_CONT]  = continuous_receive_enable_r;
    rx_rd[`SPB_RX_ADET]  = address_detect_enable_r;
    rx_rd[`SPB_RX_FRM]   = ~fifo_empty & head[9];
    rx_rd[`SPB_RX_OVR]   = overrun_error_flag_r;
    rx_rd[`SPB_RX_D9]    = ~fifo_empty & head[8];
    bd_rd = 8'h00;
    bd_rd[`SPB_BD_ABOVF]  = autobaud_overflow_flag_r;
    bd_rd[`SPB_BD_IDLE]   = receiver_idle_flag_r;
    bd_rd[`SPB_BD_POL]    = polarity_select_r;
    bd_rd[`SPB_BD_WIDE]   = wide_generator_select_r;
    bd_rd[`SPB_BD_WAKE]   = wakeup_enable_r;
    bd_rd[`SPB_BD_ABEN]   = autobaud_enable_r;
  end

  always @* begin
    addr_hit = 1'b1;
    rd_byte  = 8'h00;
    if (paddr == `SPB_OFF_TXSC) begin
      rd_byte = tx_rd;
    end else if (paddr == `SPB_OFF_RXSC) begin
      rd_byte = rx_rd;
    end else if (paddr == `SPB_OFF_BAUDC) begin
      rd_byte = bd_rd;
    end else if (paddr == `SPB_OFF_DIVL) begin
      rd_byte = divisor_low_r;
    end else if (paddr == `SPB_OFF_DIVH) begin
      rd_byte = divisor_high_r;
    end else if (paddr == `SPB_OFF_RXDATA) begin
      rd_byte = fifo_empty ? 8'h00 : head[7:0];
    end else begin
      addr_hit = 1'b0;
    end
  end

  // APB slave: one wait-free access phase, answer sampled at setup
  always @(posedge core_clk) begin
    if (!rst_n) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else begin
      pready_r  <= setup_ph;
      pslverr_r <= setup_ph & ~addr_hit;
      if (setup_ph && !pwrite) begin
        prdata_r <= {24'h00_0000, rd_byte};
      end
    end
  end

  // Transmit status and control
  always @(posedge core_clk) begin
    if (!rst_n) begin
      clock_master_select_r      <= 1'b0;
      transmit_nine_bit_select_r <= 1'b0;
      transmit_enable_bit_r      <= 1'b0;
      sync_bit_r                 <= 1'b0;
      break_request_r            <= 1'b0;
      high_rate_select_r         <= 1'b0;
      transmit_ninth_data_r      <= 1'b0;
      shift_register_empty_r     <= 1'b1;
    end else begin
      shift_register_empty_r <= ~port_enable_bit_r | txsh_empty;
      if (wr_tx) begin
        clock_master_select_r      <= pwdata[`SPB_TX_CMS];
        transmit_nine_bit_select_r <= pwdata[`SPB_TX_NINE];
        transmit_enable_bit_r      <= pwdata[`SPB_TX_EN];
        sync_bit_r                 <= pwdata[`SPB_TX_SYNC];
        high_rate_select_r         <= pwdata[`SPB_TX_HRS];
        transmit_ninth_data_r      <= pwdata[`SPB_TX_D9];
      end
      // A fresh request written with the completion keeps standing
      if (wr_tx && pwdata[`SPB_TX_BRK]) begin
        break_request_r <= 1'b1;
      end else if (!port_enable_bit_r || break_done) begin
        break_request_r <= 1'b0;
      end else if (wr_tx) begin
        break_request_r <= 1'b0;
      end
    end
  end

  // Receive status and control
  always @(posedge core_clk) begin
    if (!rst_n) begin
      port_enable_bit_r           <= 1'b0;
      receive_nine_bit_select_r   <= 1'b0;
      single_receive_enable_r     <= 1'b0;
      continuous_receive_enable_r <= 1'b0;
      address_detect_enable_r     <= 1'b0;
      overrun_error_flag_r        <= 1'b0;
    end else begin
      if (wr_rx) begin
        port_enable_bit_r           <= pwdata[`SPB_RX_PEN];
        receive_nine_bit_select_r   <= pwdata[`SPB_RX_NINE];
        continuous_receive_enable_r <= pwdata[`SPB_RX_CONT];
        address_detect_enable_r     <= pwdata[`SPB_RX_ADET];
      end
      if (wr_rx) begin
        single_receive_enable_r <= pwdata[`SPB_RX_SGL];
      end else if (single_act && rx_char_done) begin
        single_receive_enable_r <= 1'b0;
      end
      if (overrun_set) begin
        overrun_error_flag_r <= 1'b1;
      end else if (!port_enable_bit_r ||
                   (wr_rx && !pwdata[`SPB_RX_CONT])) begin
        overrun_error_flag_r <= 1'b0;
      end
    end
  end

  // Baud control and divisors
  always @(posedge core_clk) begin
    if (!rst_n) begin
      polarity_select_r        <= 1'b0;
      wide_generator_select_r  <= 1'b0;
      wakeup_enable_r          <= 1'b0;
      autobaud_enable_r        <= 1'b0;
      autobaud_overflow_flag_r <= 1'b0;
      receiver_idle_flag_r     <= 1'b1;
      divisor_low_r            <= `SPB_RST_DIV;
      divisor_high_r           <= `SPB_RST_DIV;
      div_restart_r            <= 1'b0;
    end else begin
      if (wr_bd) begin
        polarity_select_r       <= pwdata[`SPB_BD_POL];
        wide_generator_select_r <= pwdata[`SPB_BD_WIDE];
      end
      if (wr_bd && pwdata[`SPB_BD_WAKE]) begin
        wakeup_enable_r <= 1'b1;
      end else if (wake_edge || !port_enable_bit_r || wr_bd) begin
        wakeup_enable_r <= 1'b0;
      end
      if (wr_bd && pwdata[`SPB_BD_ABEN]) begin
        autobaud_enable_r <= 1'b1;
      end else if (!port_enable_bit_r || wr_bd ||
                   (autobaud_done && !sync_bit_r)) begin
        autobaud_enable_r <= 1'b0;
      end
      if (port_enable_bit_r && !sync_bit_r && autobaud_ovf) begin
        autobaud_overflow_flag_r <= 1'b1;
      end else if (!port_enable_bit_r ||
                   (wr_bd && pwdata[`SPB_BD_ABEN])) begin
        autobaud_overflow_flag_r <= 1'b0;
      end
      receiver_idle_flag_r <= ~(port_enable_bit_r & ~sync_bit_r &
                                rx_busy);
      if (wr_en && (paddr == `SPB_OFF_DIVL)) begin
        divisor_low_r <= pwdata[7:0];
      end
      if (wr_en && (paddr == `SPB_OFF_DIVH)) begin
        divisor_high_r <= pwdata[7:0];
      end
      div_restart_r <= wr_div;
    end
  end

  // Receive pin synchroniser for wake-up edge detection
  always @(posedge core_clk) begin
    if (!rst_n) begin
      rx_meta_r <= 1'b1;
      rx_sync_r <= 1'b1;
      rx_prev_r <= 1'b1;
    end else begin
      rx_meta_r <= rx_pin;
      rx_sync_r <= rx_meta_r;
      rx_prev_r <= rx_sync_r;
    end
  end

  // Receive FIFO pointers; a cleared port enable empties it
  always @(posedge core_clk) begin
    if (!rst_n || !port_enable_bit_r) begin
      wr_ptr_r   <= {PTR_W{1'b0}};
      rd_ptr_r   <= {PTR_W{1'b0}};
      fifo_cnt_r <= {(PTR_W+1){1'b0}};
      wake_flag_r <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == RX_DEPTH[PTR_W-1:0] - 1'b1) ?
                    {PTR_W{1'b0}} : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == RX_DEPTH[PTR_W-1:0] - 1'b1) ?
                    {PTR_W{1'b0}} : rd_ptr_r + 1'b1;
      end
      fifo_cnt_r  <= cnt_nxt;
      wake_flag_r <= wake_nxt;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < RX_DEPTH; gi = gi + 1) begin : g_fifo
      always @(posedge core_clk) begin
        if (!rst_n) begin
          fifo_mem_r[gi] <= 10'h000;
        end else if (push && (wr_ptr_r == gi)) begin
          // Framing error and ninth bit travel with their character
          fifo_mem_r[gi] <= {rx_char_frm, rx_char_ninth,
                             rx_char_data};
        end
      end
    end
  endgenerate

  // Effective controls towards the shift datapaths
  always @(posedge core_clk) begin
    if (!rst_n) begin
      port_enable_r            <= 1'b0;
      sync_mode_r              <= 1'b0;
      clock_master_r           <= 1'b0;
      tx_active_r              <= 1'b0;
      rx_active_r              <= 1'b0;
      tx_nine_r                <= 1'b0;
      rx_nine_r                <= 1'b0;
      tx_ninth_r               <= 1'b0;
      break_pending_r          <= 1'b0;
      polarity_r               <= 1'b0;
      wake_armed_r             <= 1'b0;
      autobaud_armed_r         <= 1'b0;
      receive_interrupt_flag_r <= 1'b0;
    end else begin
      port_enable_r  <= port_enable_bit_r;
      sync_mode_r    <= sync_bit_r;
      clock_master_r <= port_enable_bit_r & sync_bit_r &
                        clock_master_select_r;
      tx_active_r    <= port_enable_bit_r & transmit_enable_bit_r &
                        ~(sync_bit_r & (single_receive_enable_r |
                          continuous_receive_enable_r));
      rx_active_r    <= rx_on & ~overrun_error_flag_r &
                        ~(wakeup_enable_r & ~sync_bit_r);
      tx_nine_r      <= transmit_nine_bit_select_r;
      rx_nine_r      <= receive_nine_bit_select_r;
      tx_ninth_r     <= transmit_ninth_data_r;
      break_pending_r <= port_enable_bit_r & ~sync_bit_r &
                         break_request_r;
      polarity_r     <= polarity_select_r;
      wake_armed_r   <= port_enable_bit_r & ~sync_bit_r &
                        wakeup_enable_r;
      autobaud_armed_r <= port_enable_bit_r & ~sync_bit_r &
                          autobaud_enable_r;
      receive_interrupt_flag_r <= (cnt_nxt != {(PTR_W+1){1'b0}}) |
                                  wake_nxt;
    end
  end

  spb_baud_gen #(
    .DIV_W (DIV_W)
  ) u_baud (
    .core_clk     (core_clk),
    .rst_n        (rst_n),
    .run          (port_enable_bit_r),
    .restart      (div_restart_r),
    .wide         (wide_generator_select_r),
    .pre_sel      (pre_sel),
    .div_val      ({divisor_high_r, divisor_low_r}),
    .timer_tick_r (timer_tick_r),
    .bit_tick_r   (bit_tick_r)
  );
endmodule // spb_ctrl

// >>> verification/spb_dp_model.sv
// Behavioural transmit and receive datapath facing the control block
`timescale 1ns/1ns
module spb_dp_model (
  input  wire       core_clk,
  input  wire       break_pending_r,
  output reg        txsh_empty,
  output reg        rx_busy,
  output reg        rx_char_done,
  output reg  [7:0] rx_char_data,
  output reg        rx_char_ninth,
  output reg        rx_char_frm,
  output reg        break_done,
  output reg        autobaud_done,
  output reg        autobaud_ovf,
  output reg        rx_pin
);
  reg [3:0] brk_cnt_r;
  initial begin
    {txsh_empty, rx_pin, rx_busy, rx_char_done} = 4'hc;
    {rx_char_ninth, rx_char_frm, break_done} = 3'h0;
    {autobaud_done, autobaud_ovf} = 2'h0;
    rx_char_data = 8'h00;
    brk_cnt_r = 4'h0;
  end
  // A pending break occupies the shift register for a while
  always @(posedge core_clk) begin
    txsh_empty <= !break_pending_r;
    break_done <= break_pending_r && brk_cnt_r == 4'hc;
    brk_cnt_r <= break_pending_r ? brk_cnt_r + 4'h1 : 4'h0;
  end
  task send(input [7:0] d, input n, input f);
    rx_busy <= 1'h1;
    repeat (4) @(posedge core_clk);
    {rx_busy, rx_char_done, rx_char_ninth, rx_char_frm} <= {2'h1, n, f};
    rx_char_data <= d;
    @(posedge core_clk);
    // Stale character lines are not left holding the last value
    {rx_char_done, rx_char_ninth, rx_char_frm} <= {1'h0, !n, !f};
    rx_char_data <= ~d;
  endtask
  task wake_edge;
    rx_pin <= 1'h0;
    repeat (6) @(posedge core_clk);
    rx_pin <= 1'h1;
  endtask
  task abd_end;
    // Detection ends with a timer overflow reported alongside
    {autobaud_done, autobaud_ovf} <= 2'h3;
    @(posedge core_clk);
    {autobaud_done, autobaud_ovf} <= 2'h0;
  endtask
endmodule // spb_dp_model

// >>> verification/spb_ctrl_asserts.sv
// Checker of the serial port control block ports
`timescale 1ns/1ns
module spb_ctrl_asserts (
  input wire core_clk,
  input wire rst_n,
  input wire psel,
  input wire break_done,
  input wire autobaud_done,
  input wire rx_char_done,
  input wire port_enable_r,
  input wire sync_mode_r,
  input wire clock_master_r,
  input wire tx_active_r,
  input wire rx_active_r,
  input wire break_pending_r,
  input wire wake_armed_r,
  input wire autobaud_armed_r,
  input wire receive_interrupt_flag_r,
  input wire timer_tick_r
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence brk_end;
    break_pending_r && break_done && !psel;
  endsequence
  sequence abd_end;
    autobaud_armed_r && autobaud_done && !psel;
  endsequence
  master_sync_a: assert property (
    clock_master_r |-> sync_mode_r) else $error("master outside sync");
  sync_ovr_a: assert property (
    sync_mode_r && rx_active_r |-> !tx_active_r) else $error("tx not held");
  brk_async_a: assert property (
    break_pending_r |-> !sync_mode_r) else $error("break in sync");
  brk_clear_a: assert property (
    brk_end |-> ##2 !break_pending_r) else $error("break not cleared");
  disabled_a: assert property (
    !port_enable_r && !$past(port_enable_r) && !$past(port_enable_r, 2) |->
    !(tx_active_r || rx_active_r || clock_master_r || timer_tick_r))
    else $error("port active while disabled");
  rif_cause_a: assert property (
    $rose(receive_interrupt_flag_r) |-> $past(rx_char_done) ||
    $past(rx_char_done, 2) || $past(wake_armed_r) || $past(wake_armed_r, 2))
    else $error("stray receive flag");
  async_only_a: assert property (
    wake_armed_r || autobaud_armed_r |-> port_enable_r && !sync_mode_r)
    else $error("armed in sync");
  abd_clear_a: assert property (
    abd_end |-> ##2 !autobaud_armed_r) else $error("auto-baud not cleared");
endmodule // spb_ctrl_asserts
bind spb_ctrl spb_ctrl_asserts u_chk (.core_clk, .rst_n, .psel, .break_done,
  .autobaud_done, .rx_char_done, .port_enable_r, .sync_mode_r,
  .clock_master_r, .tx_active_r, .rx_active_r, .break_pending_r,
  .wake_armed_r, .autobaud_armed_r, .receive_interrupt_flag_r,
  .timer_tick_r);

// >>> verification/testbench.sv
// Self-checking testbench of the serial port control block
`timescale 1ns/1ns
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin errors++; \
  $display("CHECK FAILED %0t: got %h want %h", $time, a, e); end end
module testbench;
  logic        core_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 8'h00, q;
  logic [31:0] pwdata = 32'h0;
  logic        err;
  wire  [31:0] prdata_r;
  wire  [7:0]  rx_char_data;
  wire pready_r, pslverr_r, txsh_empty, rx_busy, rx_char_done, rx_char_ninth;
  wire rx_char_frm, break_done, autobaud_done, autobaud_ovf, rx_pin;
  wire port_enable_r, sync_mode_r, clock_master_r, tx_active_r, rx_active_r;
  wire tx_nine_r, rx_nine_r, tx_ninth_r, break_pending_r, polarity_r;
  wire wake_armed_r, autobaud_armed_r, receive_interrupt_flag_r;
  wire timer_tick_r, bit_tick_r;
  int          errors = 0, checked = 0;
  logic [7:0]  bt [5] = '{8'h00, 8'h04, 8'h00, 8'h04, 8'h14};
  logic [7:0]  bb [5] = '{8'h00, 8'h00, 8'h08, 8'h08, 8'h00};
  int          bp [5] = '{256, 64, 64, 16, 16};
  spb_ctrl DUT (.core_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata_r, .pready_r, .pslverr_r, .txsh_empty, .rx_busy, .rx_char_done,
    .rx_char_data, .rx_char_ninth, .rx_char_frm, .break_done,
    .autobaud_done, .autobaud_ovf, .rx_pin, .port_enable_r, .sync_mode_r,
    .clock_master_r, .tx_active_r, .rx_active_r, .tx_nine_r, .rx_nine_r,
    .tx_ninth_r, .break_pending_r, .polarity_r, .wake_armed_r,
    .autobaud_armed_r, .receive_interrupt_flag_r, .timer_tick_r, .bit_tick_r);
  spb_dp_model dp (.core_clk, .break_pending_r, .txsh_empty, .rx_busy,
    .rx_char_done, .rx_char_data, .rx_char_ninth, .rx_char_frm, .break_done,
    .autobaud_done, .autobaud_ovf, .rx_pin);
  initial forever #10 core_clk = ~core_clk;
  task report_and_stop;
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // One transfer; request held until pready is seen high at an edge
  task apb(input [7:0] a, input w, input [7:0] d, input [7:0] e);
    @(posedge core_clk);
    {psel, penable, pwrite} <= {1'h1, 1'h0, w};
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge core_clk);
    penable <= 1'h1;
    do @(posedge core_clk); while (pready_r !== 1'h1);
    q = prdata_r[7:0];
    err = pslverr_r;
    {psel, penable} <= 2'h0;
    @(posedge core_clk);
    @(negedge core_clk);
    if (!w) `CHK(q, e)
  endtask
  task wr(input [7:0] a, d); apb(a, 1'h1, d, 8'h00); endtask
  task rd(input [7:0] a, e); apb(a, 1'h0, 8'h00, e); endtask
  task per(input b, input int e);
    int n;
    n = 0;
    do @(posedge core_clk); while ((b ? bit_tick_r : timer_tick_r) !== 1'h1);
    do begin
      @(posedge core_clk);
      n++;
    end while ((b ? bit_tick_r : timer_tick_r) !== 1'h1);
    `CHK(n, e)
  endtask
  task t_reset;
    rd(8'h00, 8'h02);
    rd(8'h04, 8'h00);
    rd(8'h08, 8'h40);
    rd(8'h18, 8'h00);
    `CHK(err, 1'h1)
  endtask
  task t_modes;
    wr(8'h04, 8'h80);
    wr(8'h00, 8'hb0);
    `CHK({clock_master_r, tx_active_r, sync_mode_r}, 3'h7)
    wr(8'h04, 8'h90);
    `CHK({tx_active_r, rx_active_r}, 2'h1)
    wr(8'h00, 8'ha0);
    `CHK({clock_master_r, tx_active_r, sync_mode_r}, 3'h2)
    wr(8'h04, 8'h00);
    `CHK({port_enable_r, tx_active_r, rx_active_r}, 3'h0)
  endtask
  task t_baud;
    wr(8'h04, 8'h80);
    wr(8'h0c, 8'h03);
    for (int i = 0; i < 5; i++) begin
      wr(8'h00, bt[i]);
      wr(8'h08, bb[i]);
      per(1'h1, bp[i]);
    end
    per(1'h0, 4);
    wr(8'h10, 8'h01);
    per(1'h0, 4);
    wr(8'h08, 8'h08);
    per(1'h0, 260);
    wr(8'h0c, 8'h09);
    per(1'h0, 266);
  endtask
  task t_rx;
    wr(8'h00, 8'h00);
    wr(8'h04, 8'hd0);
    `CHK(rx_nine_r, 1'h1)
    @(posedge core_clk);
    dp.send(8'h5a, 1'h1, 1'h0);
    dp.send(8'ha5, 1'h0, 1'h1);
    dp.send(8'h3c, 1'h1, 1'h0);
    rd(8'h04, 8'hd3);
    rd(8'h14, 8'h5a);
    wr(8'h04, 8'hc0);
    rd(8'h04, 8'hc4);
    rd(8'h14, 8'ha5);
    `CHK(receive_interrupt_flag_r, 1'h0)
    wr(8'h04, 8'hd8);
    @(posedge core_clk);
    dp.send(8'h11, 1'h0, 1'h0);
    repeat (3) @(posedge core_clk);
    `CHK(receive_interrupt_flag_r, 1'h0)
    dp.send(8'h22, 1'h1, 1'h0);
    rd(8'h04, 8'hd9);
    rd(8'h14, 8'h22);
  endtask
  task t_single;
    wr(8'h00, 8'hb0);
    wr(8'h04, 8'ha0);
    `CHK({tx_active_r, rx_active_r}, 2'h1)
    @(posedge core_clk);
    dp.send(8'h00, 1'h0, 1'h0);
    rd(8'h04, 8'h80);
    rd(8'h14, 8'h00);
  endtask
  task t_events;
    wr(8'h00, 8'h41);
    rd(8'h00, 8'h43);
    `CHK({tx_nine_r, tx_ninth_r}, 2'h3)
    wr(8'h00, 8'h28);
    // Empty flag follows the datapath one cycle later
    @(posedge core_clk);
    rd(8'h00, 8'h28);
    repeat (20) @(posedge core_clk);
    rd(8'h00, 8'h22);
    wr(8'h08, 8'h13);
    `CHK({polarity_r, wake_armed_r, autobaud_armed_r}, 3'h7)
    rd(8'h08, 8'h53);
    @(posedge core_clk);
    dp.abd_end();
    repeat (2) @(negedge core_clk);
    `CHK(autobaud_armed_r, 1'h0)
    @(posedge core_clk);
    dp.wake_edge();
    `CHK({wake_armed_r, receive_interrupt_flag_r}, 2'h1)
    rd(8'h14, 8'h00);
    `CHK(receive_interrupt_flag_r, 1'h0)
    rd(8'h08, 8'hd0);
  endtask
  initial begin
    #400000;
    errors++;
    report_and_stop;
  end
  initial begin
    repeat (10) @(posedge core_clk);
    rst_n <= 1'h1;
    t_reset;
    t_modes;
    t_baud;
    t_rx;
    t_single;
    t_events;
    report_and_stop;
  end
endmodule // testbench
